/* File: shared/aps_pkg.sv */
package aps_pkg;

  // Register byte offsets
  localparam logic [7:0] APS_CTRL_OFF      = 8'h00;
  localparam logic [7:0] APS_LEVEL_OFF     = 8'h04;
  localparam logic [7:0] APS_HYST_OFF      = 8'h08;
  localparam logic [7:0] APS_SELECT_OFF    = 8'h0c;
  localparam logic [7:0] APS_STATUS_OFF    = 8'h10;
  localparam logic [7:0] APS_FREQ_OFF      = 8'h14;

  // Frequencies in 0.1 Hz units, 16 bits
  localparam int         APS_FW            = 16;
  localparam logic [15:0] APS_LEVEL_RST    = 16'h01f4;  // 50.0 Hz
  localparam logic [15:0] APS_HYST_RST     = 16'h000a;  // 1.0 Hz

  // Status-signal codes
  localparam logic [7:0] APS_CODE_EXTRA    = 8'h58;     // 88
  localparam logic [7:0] APS_CODE_P4LINE   = 8'ha7;     // 167
  localparam logic [7:0] APS_TSEL_RST      = 8'h00;     // 0
  localparam logic [7:0] APS_RSEL_RST      = 8'h63;     // 99
  localparam logic [7:0] APS_MODE_RST      = 8'h00;

  // CTRL field positions
  localparam int APS_CTRL_MODE_LSB  = 0;   // 8 bits pump_control_mode_select
  localparam int APS_CTRL_PMODE_LSB = 8;   // 4 x 4 bits pump mode settings
  localparam int APS_CTRL_MAP_LSB   = 24;  // 4 bits enable input mapped
  localparam int APS_SEL_TSEL_LSB   = 0;
  localparam int APS_SEL_RSEL_LSB   = 8;

  typedef struct packed {
    logic [7:0]  mode;
    logic [15:0] pmode;
    logic [3:0]  mapped;
  } aps_cfg_s;

  typedef struct packed {
    logic [7:0] tsel;
    logic [7:0] rsel;
  } aps_sel_s;

endpackage

/* File: rtl/aps_enable.sv */
`timescale 1ns/10ps
module aps_enable
  import aps_pkg::*;
(
  input  wire logic [3:0] pump_mode_setting,
  input  wire logic       enable_mapped,
  input  wire logic       pump_enable_input,
  input  wire logic       pump_running,
  output logic            pump_ok
);
  // Unmapped enable input always qualifies
  logic en_cond;
  assign en_cond = !enable_mapped || pump_enable_input;
  // Enabled needs both conditions; disabled pumps never block
  assign pump_ok = !((pump_mode_setting != 4'h0) && en_cond) || pump_running;
endmodule // aps_enable

/* File: rtl/aps_hyst.sv */
`timescale 1ns/10ps
module aps_hyst
  import aps_pkg::*;
#(
  parameter int W = APS_FW
)
(
  input  wire logic [W-1:0] freq,
  input  wire logic [W-1:0] level,
  input  wire logic [W-1:0] hyst,
  output logic              above,
  output logic              at_or_below_rel
);
  logic [W:0] rel;
  // A hysteresis wider than the level borrows into rel[W], which forces release
  assign rel = {1'b0, level} - {1'b0, hyst};
  assign above = freq > level;
  assign at_or_below_rel = rel[W] || ({1'b0, freq} <= rel);
endmodule // aps_hyst

/* File: rtl/aps_top.sv */
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
// Functional notes
// - Extra-pump signal sets only when all enabled auxiliary pumps run and frequency exceeds the level.
// - Code 88 on the transistor output selector routes the extra-pump signal there.
// - A pump's enable input must be on if mapped, and counts as on if unmapped.
// - A pump is enabled when its mode setting is nonzero and its enable condition holds.
// - Release of the extra-pump signal uses a configurable hysteresis width.
// - The signal drops once frequency is at or below level minus hysteresis.
// - The operation level resets to 50.0 Hz.
// - The hysteresis width resets to 1.0 Hz.
// - The relay selector resets to 99, and code 167 routes pump 4's line contactor there.
// - The stop-duration delay should let the extra pump drop before any auxiliary pump.
// - Pump control mode resets to 0 and staging runs only in a nonzero mode.
module aps_top
  import aps_pkg::*;
#(
  parameter int NPUMP = 4
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [APS_FW-1:0] output_frequency,
  input  wire logic [NPUMP-1:0] aux_running,
  input  wire logic [NPUMP-1:0] pump_enable_input,
  input  wire logic             pump4_line_contactor,
  output logic                  transistor_output_one,
  output logic                  alarm_relay_output
);
  import aps_pkg::*;

  initial
  begin
    if (NPUMP != 4)
      $error("aps_top supports exactly four auxiliary pumps");
  end

  aps_cfg_s          cfg_q;
  aps_sel_s          sel_q;
  logic [APS_FW-1:0] level_q;
  logic [APS_FW-1:0] hyst_q;
  logic              extra_q;
  logic              extra_d;
  logic [NPUMP-1:0]  pump_ok;
  logic              above;
  logic              release_cond;
  logic              setup_ok;
  logic              all_ok;
  logic              wr_en;
  logic              hit;

  // Zero-wait slave: pready high in every access phase
  assign wr_en = psel && penable && pwrite;
  always_comb
  begin
    case (paddr)
      APS_CTRL_OFF, APS_LEVEL_OFF, APS_HYST_OFF, APS_SELECT_OFF, APS_STATUS_OFF, APS_FREQ_OFF: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q.mode   <= APS_MODE_RST;
      cfg_q.pmode  <= 16'h0000;
      cfg_q.mapped <= 4'h0;
    end
    else if (wr_en && paddr == APS_CTRL_OFF)
    begin
      cfg_q.mode   <= pwdata[APS_CTRL_MODE_LSB +: 8];
      cfg_q.pmode  <= pwdata[APS_CTRL_PMODE_LSB +: 16];
      cfg_q.mapped <= pwdata[APS_CTRL_MAP_LSB +: 4];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      level_q <= APS_LEVEL_RST;
    else if (wr_en && paddr == APS_LEVEL_OFF)
      level_q <= pwdata[APS_FW-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hyst_q <= APS_HYST_RST;
    else if (wr_en && paddr == APS_HYST_OFF)
      hyst_q <= pwdata[APS_FW-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_q.tsel <= APS_TSEL_RST;
      sel_q.rsel <= APS_RSEL_RST;
    end
    else if (wr_en && paddr == APS_SELECT_OFF)
    begin
      sel_q.tsel <= pwdata[APS_SEL_TSEL_LSB +: 8];
      sel_q.rsel <= pwdata[APS_SEL_RSEL_LSB +: 8];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          APS_CTRL_OFF:   prdata <= {4'h0, cfg_q.mapped, cfg_q.pmode, cfg_q.mode};
          APS_LEVEL_OFF:  prdata <= {16'h0000, level_q};
          APS_HYST_OFF:   prdata <= {16'h0000, hyst_q};
          APS_SELECT_OFF: prdata <= {16'h0000, sel_q.rsel, sel_q.tsel};
          APS_STATUS_OFF: prdata <= {23'h000000, transistor_output_one, aux_running, pump_ok};
          APS_FREQ_OFF:   prdata <= {16'h0000, output_frequency};
          default:        prdata <= 32'h0000_0000;
        endcase
      end
      else
        prdata <= 32'h0000_0000; // Data stands for the access cycle only
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPUMP; g++)
    begin : g_pump
      aps_enable u_en (
        .pump_mode_setting (cfg_q.pmode[4*g +: 4]),
        .enable_mapped     (cfg_q.mapped[g]),
        .pump_enable_input (pump_enable_input[g]),
        .pump_running      (aux_running[g]),
        .pump_ok           (pump_ok[g])
      );
    end
  endgenerate

  aps_hyst #(.W(APS_FW)) u_hyst (
    .freq            (output_frequency),
    .level           (level_q),
    .hyst            (hyst_q),
    .above           (above),
    .at_or_below_rel (release_cond)
  );

  // Staging idles while pump control is off
  assign setup_ok = cfg_q.mode != APS_MODE_RST;
  assign all_ok   = &pump_ok;

  // Set needs all enabled pumps up; drop on the low threshold or in mode zero, so a dip
  // between the two levels holds the pump on
  always_comb
  begin
    extra_d = extra_q;
    if (!setup_ok)
      extra_d = 1'b0;
    else if (!extra_q && all_ok && above)
      extra_d = 1'b1;
    else if (extra_q && release_cond)
      extra_d = 1'b0;
  end

  // Staggered drop versus aux pumps relies on the stop delay setting
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      extra_q <= 1'b0;
    else
      extra_q <= extra_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      transistor_output_one <= 1'b0;
      alarm_relay_output    <= 1'b0;
    end
    else
    begin
      transistor_output_one <= (sel_q.tsel == APS_CODE_EXTRA) && extra_d;
      alarm_relay_output    <= (sel_q.rsel == APS_CODE_P4LINE) && pump4_line_contactor;
    end
  end

endmodule // aps_top

/* File: bench/aps_pumps.sv */
`timescale 1ns/10ps
module aps_pumps
(
  input  wire logic       pclk,
  input  wire logic [3:0] run_cmd,
  input  wire logic [3:0] sel_cmd,
  output logic      [3:0] aux_running,
  output logic      [3:0] pump_enable_input,
  output logic            pump4_line_contactor
);
  // Contactors pull in a clock late, so the block never sees an instant relay
  always_ff @(posedge pclk)
    aux_running <= run_cmd;
  assign pump_enable_input = sel_cmd;
  assign pump4_line_contactor = aux_running[3];
endmodule // aps_pumps

/* File: bench/aps_top_sva.sv */
`timescale 1ns/10ps
module aps_top_sva
  import aps_pkg::*;
#(
  parameter int NPUMP = 4
)
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [APS_FW-1:0] output_frequency,
  input wire logic [NPUMP-1:0]  aux_running,
  input wire logic [NPUMP-1:0]  pump_enable_input,
  input wire logic              pump4_line_contactor,
  input wire logic              transistor_output_one,
  input wire logic              alarm_relay_output
);
  // Shadow registers, as the bodies are hidden
  logic [7:0]  mode_q;
  logic [15:0] lvl_q, hys_q, sel_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) {mode_q, lvl_q, hys_q, sel_q} <= {APS_MODE_RST, APS_LEVEL_RST, APS_HYST_RST, APS_RSEL_RST, APS_TSEL_RST};
    else if (psel && penable && pready && pwrite)
      case (paddr)
        APS_CTRL_OFF: mode_q <= pwdata[7:0];
        APS_LEVEL_OFF: lvl_q <= pwdata[15:0];
        APS_HYST_OFF: hys_q <= pwdata[15:0];
        APS_SELECT_OFF: sel_q <= pwdata[15:0];
        default: ;
      endcase
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("ready late");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_rdz; !pready |-> prdata == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside access");
  property p_hold; transistor_output_one |-> {1'h0, $past(output_frequency)} + $past(hys_q) > $past(lvl_q); endproperty
  a_hold: assert property (p_hold) else $error("output held below release");
  property p_drop; transistor_output_one && {1'h0, output_frequency} + hys_q <= lvl_q |=> !transistor_output_one; endproperty
  a_drop: assert property (p_drop) else $error("output not released");
  property p_y1; transistor_output_one |-> $past(sel_q[7:0]) == APS_CODE_EXTRA; endproperty
  a_y1: assert property (p_y1) else $error("output without code");
  property p_mode; $past(mode_q) == 8'h0 |-> !transistor_output_one; endproperty
  a_mode: assert property (p_mode) else $error("staging in mode zero");
  property p_relay; alarm_relay_output == ($past(pump4_line_contactor) && $past(sel_q[15:8]) == APS_CODE_P4LINE); endproperty
  a_relay: assert property (p_relay) else $error("relay routing wrong");
endmodule // aps_top_sva

/* File: bench/aps_top_test.sv */
`timescale 1ns/10ps
module aps_top_test;
  import aps_pkg::*;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, t1, alarm, p4, er;
  logic [15:0] f = 16'h0;
  logic [3:0]  run = 4'h0, en = 4'hf, aux, pen;
  int          err_total = 0, total_checks = 0, cyc = 0;
  always #4 pclk = ~pclk;
  aps_top u_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .output_frequency(f), .aux_running(aux),
    .pump_enable_input(pen), .pump4_line_contactor(p4), .transistor_output_one(t1), .alarm_relay_output(alarm));
  aps_pumps u_pumps(.pclk(pclk), .run_cmd(run), .sel_cmd(en), .aux_running(aux), .pump_enable_input(pen),
    .pump4_line_contactor(p4));
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    if (s !== e) err_total++;
  endtask
  task wrap_up;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000) err_total++;
    if (cyc == 2000) wrap_up();
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'h0, a, 32'h0);
    chk(rd, e);
    chk({31'h0, er}, {31'h0, ee});
  endtask
  // Inputs settle through the relay lag and the registered output in two edges
  task stim(input logic [15:0] fq, input logic [3:0] r, input logic [3:0] e, input logic x);
    @(posedge pclk);
    {f, run, en} <= {fq, r, e};
    repeat (3) @(posedge pclk);
    #1;
    chk({31'h0, t1}, {31'h0, x});
  endtask
  task t_reset;
    rdchk(APS_LEVEL_OFF, 32'h1f4, 1'h0);
    rdchk(APS_HYST_OFF, 32'ha, 1'h0);
    rdchk(APS_SELECT_OFF, 32'h6300, 1'h0);
    rdchk(APS_CTRL_OFF, 32'h0, 1'h0);
    rdchk(8'h18, 32'h0, 1'h1);
    $display("reset test done");
  endtask
  task t_stage;
    apb(1'h1, APS_CTRL_OFF, 32'h02001101);
    apb(1'h1, APS_SELECT_OFF, 32'h6358);
    stim(16'h258, 4'h1, 4'hf, 1'h0);
    stim(16'h258, 4'h1, 4'hd, 1'h1);
    stim(16'h1ef, 4'h1, 4'hd, 1'h1);
    stim(16'h1ea, 4'h1, 4'hd, 1'h0);
    stim(16'h1f4, 4'h1, 4'hd, 1'h0);
    stim(16'h1f5, 4'h1, 4'hd, 1'h1);
    apb(1'h1, APS_CTRL_OFF, 32'h02001100);
    stim(16'h1f5, 4'h1, 4'hd, 1'h0);
    $display("staging test done");
  endtask
  // Level near the aux start point, level minus width near the aux stop point
  task t_tune;
    apb(1'h1, APS_CTRL_OFF, 32'h02001101);
    apb(1'h1, APS_LEVEL_OFF, 32'h1d6);
    apb(1'h1, APS_HYST_OFF, 32'h50);
    rdchk(APS_LEVEL_OFF, 32'h1d6, 1'h0);
    rdchk(APS_HYST_OFF, 32'h50, 1'h0);
    stim(16'h1d7, 4'h1, 4'hd, 1'h1);
    rdchk(APS_STATUS_OFF, 32'h11f, 1'h0);
    rdchk(APS_FREQ_OFF, 32'h1d7, 1'h0);
    stim(16'h187, 4'h1, 4'hd, 1'h1);
    stim(16'h186, 4'h1, 4'hd, 1'h0);
    $display("tuning test done");
  endtask
  task t_relay;
    apb(1'h1, APS_SELECT_OFF, 32'ha758);
    stim(16'h0, 4'h8, 4'hf, 1'h0);
    chk({31'h0, alarm}, 32'h1);
    stim(16'h0, 4'h0, 4'hf, 1'h0);
    chk({31'h0, alarm}, 32'h0);
    $display("relay test done");
  endtask
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_stage();
    t_tune();
    t_relay();
    wrap_up();
  end
endmodule // aps_top_test
bind aps_top aps_top_sva #(.NPUMP(NPUMP)) u_sva(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .output_frequency(output_frequency), .aux_running(aux_running), .pump_enable_input(pump_enable_input),
  .pump4_line_contactor(pump4_line_contactor), .transistor_output_one(transistor_output_one),
  .alarm_relay_output(alarm_relay_output));
